// ===== hw/cau_pkg.sv
package cau_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;

  // Byte offsets of the word registers.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_SUM = 6'h08;
  localparam logic [5:0] OFS_PRODUCT = 6'h0c;
  localparam logic [5:0] OFS_TEMP = 6'h10;
  localparam logic [5:0] OFS_OPERAND = 6'h14;
  localparam logic [5:0] OFS_CMD = 6'h18;
  localparam logic [5:0] OFS_STORE_HI = 6'h1c;
  localparam logic [5:0] OFS_STORE_LO = 6'h20;
  localparam logic [5:0] OFS_JUMP = 6'h24;

  // Control register fields.
  localparam int CTRL_SAT_BIT = 0;
  localparam int CTRL_SXM_BIT = 1;
  localparam int CTRL_PM_LSB = 2;
  localparam int CTRL_OSH_LSB = 4;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Status register fields.
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_TEST_BIT = 3;
  localparam int ST_COND_BIT = 4;

  // Command register fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SH_LSB = 5;
  localparam int CMD_CC_LSB = 10;
  localparam int CMD_CVAL_BIT = 13;
  localparam int CMD_OVAL_BIT = 14;

  localparam logic [4:0] SHIFT_MAX = 5'h10;
  localparam logic [4:0] HIGH_SHIFT = 5'h10;
  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_LOAD = 5'h01,
    OP_ADD = 5'h02,
    OP_SUB = 5'h03,
    OP_ADD_WITH_CARRY_IN = 5'h04,
    OP_SUBTRACT_WITH_BORROW = 5'h05,
    OP_AND = 5'h06,
    OP_OR = 5'h07,
    OP_XOR = 5'h08,
    OP_LOAD_P = 5'h09,
    OP_ADD_P = 5'h0a,
    OP_SUB_P = 5'h0b,
    OP_SHL1 = 5'h0c,
    OP_SHR1 = 5'h0d,
    OP_ROL1 = 5'h0e,
    OP_ROR1 = 5'h0f,
    OP_LEADING_BIT_ALIGN = 5'h10,
    OP_LOAD_T = 5'h11,
    OP_ADD_T = 5'h12,
    OP_SUB_T = 5'h13,
    OP_BIT = 5'h14,
    OP_BIT_T = 5'h15,
    OP_SET_FLAG_OP = 5'h16,
    OP_CLEAR_FLAG_OP = 5'h17,
    OP_LDST = 5'h18,
    OP_JUMP = 5'h19,
    OP_COND = 5'h1a
  } cau_op_t;

  typedef enum logic [2:0] {
    CC_C = 3'h0,
    CC_NC = 3'h1,
    CC_OV = 3'h2,
    CC_NOV = 3'h3,
    CC_EQ = 3'h4,
    CC_NEQ = 3'h5,
    CC_EQ_NOV = 3'h6,
    CC_C_NEQ = 3'h7
  } cau_cc_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } cau_bus_t;

endpackage

// ===== hw/cau_top.sv
// Summary of operation
// - Math unit uses sum register plus product or input path; results go back.
// - Bus operands go through input shift; products through product shift.
// - Saturate enable bit turns saturation on or off.
// - Saturated overflow sets flag and clamps to 7fffffff or 80000000.
// - Without saturation an overflowed result is written unclamped.
// - Logical operations never raise overflow.
// - Arithmetic, shifts and rotates update carry; loads, logic, control do not.
// - Add-with-carry and subtract-with-borrow use the prior carry value.
// - High-half add only sets carry; high-half subtract only clears it.
// - Carry conditions exist; set, clear and load-status write carry directly.
// - Reset forces carry to one.
// - Stored halves pass a 0 to 7 left shift; sum register unchanged.
// - High half fills from low half; low half fills with zeros.
// - One-bit shifts and rotates move the sum register through carry.
// - Right shift is arithmetic with sign extend select set, else logical.
// - Left shift ignores sign extend select and inserts zero.
// - Leading bit align normalizes the sum register by left shifts.
// - Temp-shift variants take their count from four temp register bits.
// - Indexed bit test picks the bit by the temp register low four bits.
// - Bit tests report without touching the sum register.
// - Conditions include overflow and zero, alone or combined.
// - Computed jump target is the low 16 bits of the sum register.
// - Input shift moves 16 bits left 0 to 16, sign or zero extended.
// - Product scale: 00 none, 01 left 1, 10 left 4, 11 right 6.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
module cau_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [cau_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [cau_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [cau_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic carry_o,
  output logic arith_wrap_o,
  output logic zero_sum_o,
  output logic [15:0] jump_target_o,
  output logic jump_valid_o
);
  import cau_pkg::*;

  // Byte lanes that are not enabled keep their old value.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] in_shift(input logic [15:0] d, input logic [4:0] sh,
                                           input logic sign_extend_select);
    logic [31:0] ext;
    logic [4:0] n;
    ext = {{16{sign_extend_select & d[15]}}, d};
    // Counts above sixteen clamp to sixteen, the widest the input path can scale.
    n = (sh > SHIFT_MAX) ? SHIFT_MAX : sh;
    return ext << n;
  endfunction

  // State.
  cau_bus_t bus_q, bus_d;
  logic wreq_q, wreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [6:0] ctrl_q, ctrl_d;
  logic [31:0] sum_q, sum_d;
  logic [31:0] prod_q, prod_d;
  logic [15:0] temp_q, temp_d;
  logic [15:0] opnd_q, opnd_d;
  logic carry_q, carry_d;
  logic ovf_q, ovf_d;
  logic zero_q, zero_d;
  logic test_q, test_d;
  logic cond_q, cond_d;
  logic [15:0] jump_q, jump_d;
  logic jvalid_q, jvalid_d;

  // Decoded fields.
  logic sat_en, sign_extend_select;
  logic [1:0] pm;
  logic [2:0] osh;
  logic [31:0] cmd_w;
  cau_op_t op;
  logic [4:0] sh_cmd;
  cau_cc_t cc;
  logic [31:0] ps_out, is_cmd, is_temp;
  logic [31:0] st_hi_full, st_lo_full;
  logic accept;
  logic cmd_take;
  logic [31:0] wr_ctrl, wr_prod, wr_temp, wr_opnd;

  assign sat_en = ctrl_q[CTRL_SAT_BIT];
  assign sign_extend_select = ctrl_q[CTRL_SXM_BIT];
  assign pm = ctrl_q[CTRL_PM_LSB +: 2];
  assign osh = ctrl_q[CTRL_OSH_LSB +: 3];
  assign cmd_w = be_merge(32'h00000000, avs_writedata_i, avs_byteenable_i);
  assign op = cau_op_t'(cmd_w[CMD_OP_LSB +: 5]);
  assign sh_cmd = cmd_w[CMD_SH_LSB +: 5];
  assign cc = cau_cc_t'(cmd_w[CMD_CC_LSB +: 3]);
  // A request is served at the one edge where waitrequest stands low.
  assign accept = (avs_read_i | avs_write_i) & (bus_q == BUS_ANSWER);
  assign cmd_take = accept && avs_write_i && (avs_address_i == OFS_CMD);

  // Byte-lane merges of the writable registers, sliced where they are used.
  assign wr_ctrl = be_merge({25'h0000000, ctrl_q}, avs_writedata_i, avs_byteenable_i);
  assign wr_prod = be_merge(prod_q, avs_writedata_i, avs_byteenable_i);
  assign wr_temp = be_merge({16'h0000, temp_q}, avs_writedata_i, avs_byteenable_i);
  assign wr_opnd = be_merge({16'h0000, opnd_q}, avs_writedata_i, avs_byteenable_i);

  // Product shift path.
  always_comb begin
    case (pm)
      2'b00: ps_out = prod_q;
      2'b01: ps_out = prod_q << 1;
      2'b10: ps_out = prod_q << 4;
      // The right shift keeps the sign so that scaled negative products stay negative.
      default: ps_out = $signed(prod_q) >>> 6;
    endcase
  end

  // Input shift path, by command count or by four temp register bits.
  assign is_cmd = in_shift(opnd_q, sh_cmd, sign_extend_select);
  assign is_temp = in_shift(opnd_q, {1'b0, temp_q[3:0]}, sign_extend_select);

  // Output shifter on stores; the sum register is only read here.
  assign st_hi_full = sum_q << osh;
  assign st_lo_full = {16'h0000, sum_q[15:0]} << osh;

  // Datapath next state.
  logic [31:0] b_op;
  logic [32:0] u_res, s_res;
  logic is_arith, is_sub, use_c, hi_mode;
  logic c_new, ov_new;
  logic [31:0] a_res;

  always_comb begin
    sum_d = sum_q;
    carry_d = carry_q;
    ovf_d = ovf_q;
    test_d = test_q;
    cond_d = cond_q;
    jump_d = jump_q;
    jvalid_d = 1'b0;
    b_op = is_cmd;
    is_arith = 1'b0;
    is_sub = 1'b0;
    use_c = 1'b0;
    hi_mode = 1'b0;
    u_res = 33'h000000000;
    s_res = 33'h000000000;
    c_new = carry_q;
    ov_new = 1'b0;
    a_res = sum_q;
    if (cmd_take) begin
      // Only arithmetic commands write the sum through the adder or set overflow from it; load-status and condition commands also write overflow.
      case (op)
        OP_ADD, OP_SUB, OP_ADD_WITH_CARRY_IN, OP_SUBTRACT_WITH_BORROW, OP_ADD_P, OP_SUB_P, OP_ADD_T, OP_SUB_T: begin
          is_arith = 1'b1;
        end
        default: is_arith = 1'b0;
      endcase
      case (op)
        OP_ADD_P, OP_SUB_P: b_op = ps_out;
        OP_ADD_T, OP_SUB_T: b_op = is_temp;
        default: b_op = is_cmd;
      endcase
      is_sub = (op == OP_SUB) || (op == OP_SUBTRACT_WITH_BORROW) || (op == OP_SUB_P) || (op == OP_SUB_T);
      use_c = (op == OP_ADD_WITH_CARRY_IN) ? carry_q : ((op == OP_SUBTRACT_WITH_BORROW) ? ~carry_q : 1'b0);
      // Only the plain add and subtract into the high half use the one-way carry.
      hi_mode = (op == OP_ADD || op == OP_SUB) && sh_cmd == HIGH_SHIFT;
      if (is_sub) begin
        u_res = {1'b0, sum_q} - {1'b0, b_op} - {32'h00000000, use_c};
        s_res = {sum_q[31], sum_q} - {b_op[31], b_op} - {32'h00000000, use_c};
        // After a subtract carry is the inverse of borrow, so one means no borrow.
        c_new = ~u_res[32];
      end else begin
        u_res = {1'b0, sum_q} + {1'b0, b_op} + {32'h00000000, use_c};
        s_res = {sum_q[31], sum_q} + {b_op[31], b_op} + {32'h00000000, use_c};
        c_new = u_res[32];
      end
      ov_new = s_res[32] != s_res[31];
      if (ov_new && sat_en) begin
        a_res = s_res[32] ? SAT_NEG : SAT_POS;
      end else begin
        a_res = s_res[31:0];
      end
      if (is_arith) begin
        sum_d = a_res;
        if (ov_new) begin
          ovf_d = 1'b1;
        end
        if (hi_mode && !is_sub) begin
          carry_d = carry_q | c_new;
        end else if (hi_mode) begin
          carry_d = carry_q & c_new;
        end else begin
          carry_d = c_new;
        end
      end
      case (op)
        OP_LOAD: sum_d = is_cmd;
        OP_LOAD_P: sum_d = ps_out;
        OP_LOAD_T: sum_d = is_temp;
        OP_AND: sum_d = sum_q & is_cmd;
        OP_OR: sum_d = sum_q | is_cmd;
        OP_XOR: sum_d = sum_q ^ is_cmd;
        OP_SHL1: begin
          sum_d = {sum_q[30:0], 1'b0};
          carry_d = sum_q[31];
        end
        OP_SHR1: begin
          sum_d = {sign_extend_select & sum_q[31], sum_q[31:1]};
          carry_d = sum_q[0];
        end
        OP_ROL1: begin
          sum_d = {sum_q[30:0], carry_q};
          carry_d = sum_q[31];
        end
        OP_ROR1: begin
          sum_d = {carry_q, sum_q[31:1]};
          carry_d = sum_q[0];
        end
        OP_LEADING_BIT_ALIGN: begin
          // One step per command; software repeats it until bits 31 and 30 differ.
          if (sum_q != 32'h00000000 && sum_q[31] == sum_q[30]) begin
            sum_d = {sum_q[30:0], 1'b0};
          end
        end
        OP_BIT: test_d = opnd_q[sh_cmd[3:0]];
        OP_BIT_T: test_d = opnd_q[temp_q[3:0]];
        OP_SET_FLAG_OP: carry_d = 1'b1;
        OP_CLEAR_FLAG_OP: carry_d = 1'b0;
        OP_LDST: begin
          carry_d = cmd_w[CMD_CVAL_BIT];
          ovf_d = cmd_w[CMD_OVAL_BIT];
        end
        OP_JUMP: begin
          jump_d = sum_q[15:0];
          jvalid_d = 1'b1;
        end
        OP_COND: begin
          case (cc)
            CC_C: cond_d = carry_q;
            CC_NC: cond_d = ~carry_q;
            CC_OV: cond_d = ovf_q;
            CC_NOV: cond_d = ~ovf_q;
            CC_EQ: cond_d = zero_q;
            CC_NEQ: cond_d = ~zero_q;
            CC_EQ_NOV: cond_d = zero_q & ~ovf_q;
            default: cond_d = carry_q & ~zero_q;
          endcase
          // Testing a condition consumes the sticky overflow flag, as a branch on it does.
          ovf_d = 1'b0;
        end
        default: sum_d = sum_d;
      endcase
    end
    // The zero flag follows the value the sum register is about to take.
    zero_d = (sum_d == 32'h00000000);
  end

  // Bus slave and software-written registers.
  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    prod_d = prod_q;
    temp_d = temp_q;
    opnd_d = opnd_q;
    case (bus_q)
      BUS_IDLE: begin
        if (avs_read_i | avs_write_i) begin
          // Read data are captured on the wait cycle and stand while waitrequest is low.
          bus_d = BUS_ANSWER;
          rdata_d = 32'h00000000;
          if (avs_read_i) begin
            case (avs_address_i)
              OFS_CTRL: rdata_d = {25'h0000000, ctrl_q};
              OFS_STATUS: rdata_d = {27'h0000000, cond_q, test_q, zero_q, ovf_q, carry_q};
              OFS_SUM: rdata_d = sum_q;
              OFS_PRODUCT: rdata_d = prod_q;
              OFS_TEMP: rdata_d = {16'h0000, temp_q};
              OFS_OPERAND: rdata_d = {16'h0000, opnd_q};
              OFS_STORE_HI: rdata_d = {16'h0000, st_hi_full[31:16]};
              OFS_STORE_LO: rdata_d = {16'h0000, st_lo_full[15:0]};
              OFS_JUMP: rdata_d = {16'h0000, jump_q};
              default: rdata_d = 32'h00000000;
            endcase
          end
        end
      end
      BUS_ANSWER: begin
        bus_d = BUS_IDLE;
        if (accept && avs_write_i) begin
          case (avs_address_i)
            OFS_CTRL: ctrl_d = wr_ctrl[6:0];
            OFS_PRODUCT: prod_d = wr_prod;
            OFS_TEMP: temp_d = wr_temp[15:0];
            OFS_OPERAND: opnd_d = wr_opnd[15:0];
            default: ctrl_d = ctrl_q;
          endcase
        end
      end
      default: bus_d = BUS_IDLE;
    endcase
    // Waitrequest has its own flop so that the output needs no decode.
    wreq_d = (bus_d != BUS_ANSWER);
  end

  // Bus slave flops.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_q <= BUS_IDLE;
      wreq_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
      prod_q <= 32'h00000000;
      temp_q <= 16'h0000;
      opnd_q <= 16'h0000;
    end else if (ce_i) begin
      bus_q <= bus_d;
      wreq_q <= wreq_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      prod_q <= prod_d;
      temp_q <= temp_d;
      opnd_q <= opnd_d;
    end
  end

  // Datapath flops.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_q <= 32'h00000000;
      carry_q <= 1'b1;
      ovf_q <= 1'b0;
      zero_q <= 1'b1;
      test_q <= 1'b0;
      cond_q <= 1'b0;
      jump_q <= 16'h0000;
      jvalid_q <= 1'b0;
    end else if (ce_i) begin
      sum_q <= sum_d;
      carry_q <= carry_d;
      ovf_q <= ovf_d;
      zero_q <= zero_d;
      test_q <= test_d;
      cond_q <= cond_d;
      jump_q <= jump_d;
      jvalid_q <= jvalid_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wreq_q;
  assign carry_o = carry_q;
  assign arith_wrap_o = ovf_q;
  assign zero_sum_o = zero_q;
  assign jump_target_o = jump_q;
  assign jump_valid_o = jvalid_q;

endmodule

// ===== verif/cau_checker.sv
module cau_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [cau_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [cau_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic carry_o,
  input wire logic arith_wrap_o,
  input wire logic zero_sum_o,
  input wire logic jump_valid_o
);
  import cau_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic take;
  logic [4:0] opc;
  // A command executes only at the edge where its write is answered.
  assign take = avs_write_i && !avs_waitrequest_o && ce_i && avs_address_i == OFS_CMD;
  assign opc = avs_writedata_i[4:0];
  sequence s_cmd(logic [4:0] o);
    take && opc == o;
  endsequence
  sequence s_pulse;
    jump_valid_o ##1 !jump_valid_o;
  endsequence
  property p_rst_carry;
    $rose(rst_b_i) |-> carry_o;
  endproperty
  a_rst_carry: assert property (p_rst_carry) else $error("carry low after reset");
  property p_carry_hold;
    !take || opc inside {OP_NOP, OP_LOAD, OP_LOAD_P, OP_LOAD_T, OP_AND, OP_OR, OP_XOR}
      |=> $stable(carry_o);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved");
  property p_set_flag_op;
    s_cmd(OP_SET_FLAG_OP) |=> carry_o;
  endproperty
  a_set_flag_op: assert property (p_set_flag_op) else $error("carry not set");
  property p_clear_flag_op;
    s_cmd(OP_CLEAR_FLAG_OP) |=> !carry_o;
  endproperty
  a_clear_flag_op: assert property (p_clear_flag_op) else $error("carry not cleared");
  property p_logic_ovf;
    take && opc inside {OP_AND, OP_OR, OP_XOR} |=> $stable(arith_wrap_o);
  endproperty
  a_logic_ovf: assert property (p_logic_ovf) else $error("logic op moved overflow");
  property p_bit_sum;
    take && opc inside {OP_BIT, OP_BIT_T} |=> $stable(zero_sum_o);
  endproperty
  a_bit_sum: assert property (p_bit_sum) else $error("bit test moved sum");
  property p_jump;
    s_cmd(OP_JUMP) |=> s_pulse;
  endproperty
  a_jump: assert property (p_jump) else $error("jump pulse wrong");
  property p_jump_cause;
    jump_valid_o |-> $past(take) && $past(opc) == OP_JUMP;
  endproperty
  a_jump_cause: assert property (p_jump_cause) else $error("jump pulse unasked");
endmodule

bind cau_top cau_checker u_cau_checker (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
  .carry_o(carry_o), .arith_wrap_o(arith_wrap_o), .zero_sum_o(zero_sum_o),
  .jump_valid_o(jump_valid_o));

// ===== verif/cau_seq_model.sv
module cau_seq_model (
  input wire logic clk_sys_i,
  input wire logic [cau_pkg::DATA_W-1:0] rdata_i,
  input wire logic wait_i,
  output logic [cau_pkg::ADDR_W-1:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [cau_pkg::DATA_W-1:0] wdata_o
);
  import cau_pkg::*;
  initial begin
    addr_o = '0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = '0;
  end
  // Called at a rising edge; holds the request until waitrequest is seen low.
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // One idle edge keeps a following request from reassigning in this step.
    @(posedge clk_sys_i);
  endtask
endmodule

// ===== verif/tb_cau_top.sv
module tb_cau_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cau_pkg::*;
  logic clk_sys_i;
  logic rst_b_i = 1'b0;
  logic rd, wr, wt, cy, ov, zs, jv;
  logic [5:0] adr;
  logic [31:0] wd, rdat;
  logic [15:0] jt;
  logic [31:0] lfsr_q = 32'h36697737;
  int num_errors = 0;
  int tests_run = 0;
  cau_top u_cau_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .carry_o(cy),
    .arith_wrap_o(ov), .zero_sum_o(zs), .jump_target_o(jt), .jump_valid_o(jv));
  cau_seq_model u_seq (.clk_sys_i(clk_sys_i), .rdata_i(rdat), .wait_i(wt), .addr_o(adr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] rnd();
    repeat (8) lfsr_q = (lfsr_q >> 1) ^ (lfsr_q[0] ? 32'h80200003 : 32'h0);
    return lfsr_q;
  endfunction
  function automatic logic [31:0] isx(logic [15:0] d, logic sx, logic [4:0] s);
    return (sx ? {{16{d[15]}}, d} : {16'h0, d}) << s;
  endfunction
  function automatic logic [32:0] shf(int j, logic [31:0] v, logic c);
    case (j)
      0: return {v, 1'b0};
      1: return {v[0], 1'b0, v[31:1]};
      2: return {v[0], v[31], v[31:1]};
      3: return {v, c};
      default: return {v[0], c, v[31:1]};
    endcase
  endfunction
  function automatic logic cnd(logic [2:0] cc, logic c, logic o, logic z);
    logic [7:0] t;
    t = {c & !z, z & !o, !z, z, !o, o, !c, c};
    return t[cc];
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_seq.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [5:0] a, output logic [31:0] q);
    u_seq.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic op(input logic [4:0] o, input logic [4:0] s);
    w(OFS_CMD, {22'h0, s, o});
  endtask
  task automatic ldsum(input logic [31:0] d);
    w(OFS_PRODUCT, d);
    w(OFS_CTRL, 32'h0);
    op(OP_LOAD_P, 5'h0);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    logic [31:0] v, e, q, b;
    logic [32:0] t;
    logic [4:0] s;
    logic [3:0] idx;
    logic cx;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    cx = 1'b1;
    chk("carry reset", 32'h1, 32'(cy));
    r(OFS_STATUS, q);
    chk("status reset", 32'h5, q & 32'h7);
    r(6'h3c, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      s = i[0] ? HIGH_SHIFT : 5'(v[19:16]);
      w(OFS_CTRL, {30'h0, v[24], 1'b0});
      w(OFS_OPERAND, {16'h0, v[15:0]});
      w(OFS_TEMP, {16'h0, v[31:20], s[3:0]});
      if (i[1]) begin
        op(OP_LOAD_T, 5'h0);
        s = {1'b0, s[3:0]};
      end else begin
        op(OP_LOAD, s);
      end
      r(OFS_SUM, q);
      chk("load", isx(v[15:0], v[24], s), q);
      chk("load carry", 32'(cx), 32'(cy));
    end
    for (int m = 0; m < 4; m++) begin
      v = rnd() & 32'h7fffffff;
      w(OFS_PRODUCT, v);
      w(OFS_CTRL, 32'(m << 2));
      op(OP_LOAD_P, 5'h0);
      r(OFS_SUM, q);
      e = m == 0 ? v : m == 1 ? v << 1 : m == 2 ? v << 4 : v >> 6;
      chk("product_shift_path", e, q);
    end
    $display("test shifters done");
    for (int k = 0; k < 4; k++) begin
      ldsum(k[1] ? SAT_NEG : SAT_POS);
      op(OP_COND, 5'h0);
      w(OFS_CTRL, {31'h0, k[0]});
      w(OFS_OPERAND, 32'h1);
      op(k[1] ? OP_SUB : OP_ADD, 5'h0);
      cx = k[1];
      r(OFS_SUM, q);
      chk("ovf sum", (k[0] ^ k[1]) ? SAT_POS : SAT_NEG, q);
      chk("ovf flag", 32'h1, 32'(ov));
      chk("ovf carry", 32'(cx), 32'(cy));
    end
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      e = rnd();
      ldsum(v);
      op(OP_COND, 5'h0);
      w(OFS_OPERAND, {16'h0, e[15:0]});
      op(5'(OP_AND + k), 5'h8);
      e = {8'h0, e[15:0], 8'h0};
      r(OFS_SUM, q);
      chk("logic", k == 0 ? v & e : k == 1 ? v | e : v ^ e, q);
      chk("logic ovf", 32'h0, 32'(ov));
      chk("logic carry", 32'(cx), 32'(cy));
    end
    $display("test overflow done");
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      e = rnd() & 32'hffff;
      ldsum(v);
      op(k[0] ? OP_SET_FLAG_OP : OP_CLEAR_FLAG_OP, 5'h0);
      w(OFS_OPERAND, e);
      op(k[1] ? OP_SUBTRACT_WITH_BORROW : OP_ADD_WITH_CARRY_IN, 5'h0);
      t = k[1] ? {1'b0, v} - {1'b0, e} - 33'(!k[0]) : {1'b0, v} + {1'b0, e} + 33'(k[0]);
      cx = k[1] ? !t[32] : t[32];
      r(OFS_SUM, q);
      chk("carry op sum", t[31:0], q);
      chk("carry op carry", 32'(cx), 32'(cy));
    end
    for (int k = 0; k < 4; k++) begin
      ldsum((k[0] == k[1]) ? 32'hffff0000 : 32'h0);
      op((k[0] ^ k[1]) ? OP_SET_FLAG_OP : OP_CLEAR_FLAG_OP, 5'h0);
      w(OFS_OPERAND, 32'h1);
      op(k[1] ? OP_SUB : OP_ADD, HIGH_SHIFT);
      cx = !k[1];
      chk("high carry", 32'(cx), 32'(cy));
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      e = rnd();
      ldsum(v);
      w(OFS_PRODUCT, e);
      w(OFS_OPERAND, {16'h0, e[15:0]});
      w(OFS_TEMP, {16'h0, e[31:16]});
      op(5'(k[1] ? OP_ADD_T + k[0] : OP_ADD_P + k[0]), 5'h0);
      b = k[1] ? isx(e[15:0], 1'b0, {1'b0, e[19:16]}) : e;
      t = k[0] ? {1'b0, v} - {1'b0, b} : {1'b0, v} + {1'b0, b};
      cx = k[0] ? !t[32] : t[32];
      r(OFS_SUM, q);
      chk("unit sum", t[31:0], q);
      chk("unit carry", 32'(cx), 32'(cy));
    end
    for (int j = 0; j < 5; j++) begin
      v = rnd();
      ldsum(v);
      op(v[5] ? OP_SET_FLAG_OP : OP_CLEAR_FLAG_OP, 5'h0);
      w(OFS_CTRL, {30'h0, j == 0 || j == 2, 1'b0});
      op(5'(OP_SHL1 + (j > 1 ? j - 1 : j)), 5'h0);
      t = shf(j, v, v[5]);
      cx = t[32];
      r(OFS_SUM, q);
      chk("shift sum", t[31:0], q);
      chk("shift carry", 32'(cx), 32'(cy));
    end
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 32'h0 : rnd() >> k;
      ldsum(v);
      op(OP_LEADING_BIT_ALIGN, 5'h0);
      e = (v != 32'h0 && v[31] == v[30]) ? v << 1 : v;
      r(OFS_SUM, q);
      chk("leading_bit_align", e, q);
      chk("leading_bit_align zero", 32'(e == 32'h0), 32'(zs));
      chk("leading_bit_align carry", 32'(cx), 32'(cy));
    end
    $display("test carry done");
    v = rnd();
    ldsum(v);
    for (int n = 0; n < 8; n++) begin
      w(OFS_CTRL, 32'(n << 4));
      e = v << n;
      r(OFS_STORE_HI, q);
      chk("store hi", {16'h0, e[31:16]}, q);
      r(OFS_STORE_LO, q);
      chk("store lo", {16'h0, v[15:0] << n}, q);
    end
    w(OFS_SUM, ~v);
    for (int k = 0; k < 4; k++) begin
      e = rnd();
      w(OFS_OPERAND, {16'h0, e[15:0]});
      w(OFS_TEMP, {16'h0, e[31:16]});
      idx = k[0] ? e[19:16] : e[23:20];
      op(k[0] ? OP_BIT_T : OP_BIT, {1'b0, e[23:20]});
      r(OFS_STATUS, q);
      chk("bit test", 32'(e[idx]), 32'(q[ST_TEST_BIT]));
      r(OFS_SUM, q);
      chk("sum kept", v, q);
    end
    $display("test store and bit done");
    for (int k = 0; k < 16; k++) begin
      e = rnd();
      ldsum({31'h0, e[0]});
      chk("zero pin", 32'(!e[0]), 32'(zs));
      w(OFS_CMD, {17'h0, e[2], e[1], 8'h0, OP_LDST});
      cx = e[1];
      chk("ldst carry", 32'(cx), 32'(cy));
      w(OFS_CMD, {19'h0, 3'(k), 5'h0, OP_COND});
      r(OFS_STATUS, q);
      chk("cond", 32'(cnd(3'(k), e[1], e[2], !e[0])), 32'(q[ST_COND_BIT]));
    end
    v = rnd();
    ldsum(v);
    op(OP_JUMP, 5'h0);
    r(OFS_JUMP, q);
    chk("jump reg", {16'h0, v[15:0]}, q);
    chk("jump pin", {16'h0, v[15:0]}, {16'h0, jt});
    $display("test branch done");
    op(OP_CLEAR_FLAG_OP, 5'h0);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("carry mid reset", 32'h1, 32'(cy));
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    r(OFS_CTRL, q);
    chk("ctrl reset", 32'h0, q);
    $display("test second reset done");
    test_done();
  end
endmodule
